/* verilog/adc_peak_hold.v */
// result, peak, hold, calibration and power control of the converter
// assumes a host register port already decoded to index, data, strobes
// Summary of operation
// - sixteen-bit read-only peak register, cleared to zero at reset
// - setting peak enable first loads present result as starting peak
// - during tracking, peak is replaced only by a larger new result
// - clearing peak enable clears the peak register
// - tracking guaranteed only within the documented count ranges
// - peak holds two's complement; narrow variant uses D15 to D4
// - eight-bit low result register, bits in upper nibble, lower zero
// - reset returns interface, display, filter and registers to default
// - continuous calibration disable low means calibrate every conversion
// - writing enhanced calibration bit one starts enhanced calibration
// - digital power-down stops filter and display, independent of analog
// - analog power-down stops modulator and buffers, independent of digital
// - peak enable shows only the highest measured value
// - hold freezes display on the reading present at activation
// - low battery input sets status flag and display annunciator
// - negative display values show magnitude reduced by one
// - display data comes from result, peak or host by control bits
// - final result is calibrated input minus custom offset register
// - upper result register holds sixteen result MSBs, read-only
`timescale 1ns/10ps
`include "adc_result_map.vh"
module adc_peak_hold #(
   parameter RES_WIDTH = 20,
   parameter CAL_CYCLES = 8
) (
   input wire ref_clk,
   input wire rst,
   // host register port
   input wire [3:0] regIndex,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [15:0] regRdData,
   output reg regRdValid,
   // converter side
   input wire [RES_WIDTH-1:0] calibratedSample,
   input wire sampleValid,
   input wire lowBatteryPin,
   // control outputs to the analog and display sections
   output reg offsetCalPerConversion,
   output reg enhancedCalActive,
   output reg filterPowerdown,
   output reg displayPowerdown,
   output reg modulatorPowerdown,
   output reg inputBufferPowerdown,
   output reg segmentDirectSelect,
   output reg displayNegative,
   output reg [15:0] displayMagnitude,
   output reg peakAnnunciator,
   output reg holdAnnunciator,
   output reg batteryLowAnnunciator
);
   // ==========================================================
   // registers
   reg [15:0] control;
   reg [15:0] customOffset;
   reg [15:0] resultHigh;
   reg [7:0] resultLowNibble;
   reg [15:0] peakValue;
   reg [15:0] displayData;
   reg peakArmed;
   reg holdPrev;
   reg battSync1, battSync2, battSync3;
   reg batteryLowFlag;
   reg [7:0] enhCalCount;
   reg sampleSeen;

   wire peakEnable = control[`CTRL_PEAK];
   wire holdEnable = control[`CTRL_HOLD];
   wire hostSource = control[`CTRL_HOST_SRC];
   wire digitalPowerdown = control[`CTRL_DIG_PD];
   wire analogPowerdown = control[`CTRL_ANA_PD];

   // ==========================================================
   // result path
   // subtract the custom offset, aligned to the upper sixteen bits
   wire [RES_WIDTH-1:0] offsetAligned = {customOffset, 4'h0};
   wire [RES_WIDTH-1:0] finalResult = calibratedSample - offsetAligned;
   wire [15:0] newHigh = finalResult[RES_WIDTH-1:RES_WIDTH-16];
   // converter stops delivering while the filter is powered down
   wire sampleTake = sampleValid & ~digitalPowerdown;

   // result registers, updated per conversion
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         resultHigh <= `WORD_RESET;
         resultLowNibble <= `RESLO_RESET;
         sampleSeen <= 1'b0;
      end else if (sampleTake) begin
         resultHigh <= newHigh;
         resultLowNibble <= {finalResult[3:0], 4'h0};
         sampleSeen <= 1'b1;
      end
   end

   // ==========================================================
   // peak tracking
   // signed compare; strict greater so equal leaves peak alone
   wire newLarger = $signed(newHigh) > $signed(peakValue);
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         peakValue <= `PEAK_RESET;
         peakArmed <= 1'b0;
      end else if (!peakEnable) begin
         peakValue <= `PEAK_RESET;
         peakArmed <= 1'b0;
      end else if (!peakArmed) begin
         peakValue <= resultHigh;
         peakArmed <= 1'b1;
      end else if (sampleTake && newLarger) begin
         peakValue <= newHigh;
      end
   end

   // ==========================================================
   // display data source
   // host writes win in host mode; hold freezes; peak shows maximum
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         displayData <= `WORD_RESET;
         holdPrev <= 1'b0;
      end else begin
         holdPrev <= holdEnable;
         if (hostSource) begin
            if (regWrite && regIndex == `REG_DISP_DATA) begin
               displayData <= regWrData;
            end
         end else if (holdEnable) begin
            if (!holdPrev) begin
               displayData <= displayData;
            end
         end else if (peakEnable) begin
            displayData <= peakValue;
         end else begin
            displayData <= resultHigh;
         end
      end
   end

   // ==========================================================
   // low battery input, three-stage synchroniser
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         battSync1 <= 1'b0;
         battSync2 <= 1'b0;
         battSync3 <= 1'b0;
         batteryLowFlag <= 1'b0;
      end else begin
         battSync1 <= lowBatteryPin;
         battSync2 <= battSync1;
         battSync3 <= battSync2;
         if (battSync2 == battSync3) begin
            batteryLowFlag <= battSync3;
         end
      end
   end

   // ==========================================================
   // control register, enhanced calibration sequencing
   wire ctrlWrite = regWrite && regIndex == `REG_CTRL;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         control <= `CTRL_RESET;
         customOffset <= `WORD_RESET;
         enhCalCount <= 8'h00;
      end else begin
         if (ctrlWrite) begin
            control <= regWrData;
         end else if (enhCalCount == 8'h01) begin
            control[`CTRL_ENH_CAL] <= 1'b0; // self-clears when done
         end
         if (regWrite && regIndex == `REG_OFFSET) begin
            customOffset <= regWrData;
         end
         if (ctrlWrite && regWrData[`CTRL_ENH_CAL]) begin
            enhCalCount <= `ENH_CAL_CYCLES;
         end else if (enhCalCount != 8'h00) begin
            enhCalCount <= enhCalCount - 8'h01;
         end
      end
   end

   // ==========================================================
   // register read port
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         regRdData <= `WORD_RESET;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (regRead) begin
            case (regIndex)
               `REG_CTRL: regRdData <= control;
               `REG_STATUS: regRdData <= {14'h0000,
                  enhCalCount != 8'h00, batteryLowFlag};
               `REG_OFFSET: regRdData <= customOffset;
               `REG_RESULT_HI: regRdData <= resultHigh;
               `REG_RESULT_LO: regRdData <= {8'h00, resultLowNibble};
               `REG_DISP_DATA: regRdData <= displayData;
               `REG_PEAK: regRdData <= peakValue;
               default: regRdData <= `WORD_RESET;
            endcase
         end
      end
   end

   // ==========================================================
   // display conversion and registered outputs
   wire magNeg;
   wire [15:0] magVal;
   disp_magnitude #(
      .WIDTH(16)
   ) u_disp_magnitude (
      .value(displayData),
      .negative(magNeg),
      .magnitude(magVal)
   );

   // outputs all registered; display outputs keep being driven during digital power-down
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         offsetCalPerConversion <= 1'b1;
         enhancedCalActive <= 1'b0;
         filterPowerdown <= 1'b0;
         displayPowerdown <= 1'b0;
         modulatorPowerdown <= 1'b0;
         inputBufferPowerdown <= 1'b0;
         segmentDirectSelect <= 1'b0;
         displayNegative <= 1'b0;
         displayMagnitude <= `WORD_RESET;
         peakAnnunciator <= 1'b0;
         holdAnnunciator <= 1'b0;
         batteryLowAnnunciator <= 1'b0;
      end else begin
         offsetCalPerConversion <= ~control[`CTRL_CONT_CAL_DIS];
         enhancedCalActive <= enhCalCount != 8'h00;
         filterPowerdown <= digitalPowerdown;
         displayPowerdown <= digitalPowerdown;
         modulatorPowerdown <= analogPowerdown;
         inputBufferPowerdown <= analogPowerdown;
         segmentDirectSelect <= control[`CTRL_SEGMENT_DIRECT_SELECT];
         displayNegative <= magNeg;
         displayMagnitude <= magVal;
         peakAnnunciator <= peakEnable;
         holdAnnunciator <= holdEnable;
         batteryLowAnnunciator <= batteryLowFlag;
      end
   end
endmodule // adc_peak_hold

/* verilog/adc_result_map.vh */
// constants for the converter result, peak and display control logic
// assumes inclusion by bare name from the design files
`ifndef ADC_RESULT_MAP_VH
`define ADC_RESULT_MAP_VH
// register indices on the host register port
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_OFFSET 4'h2
`define REG_RESULT_HI 4'h3
`define REG_RESULT_LO 4'h4
`define REG_DISP_DATA 4'h5
`define REG_PEAK 4'h6
// control register field positions
`define CTRL_PEAK 0
`define CTRL_HOLD 1
`define CTRL_HOST_SRC 2
`define CTRL_CONT_CAL_DIS 3
`define CTRL_ENH_CAL 4
`define CTRL_DIG_PD 5
`define CTRL_ANA_PD 6
`define CTRL_SEGMENT_DIRECT_SELECT 7
// status register field positions
`define STAT_BATT_LOW 0
`define STAT_CAL_BUSY 1
// reset values
`define CTRL_RESET 16'h0000
`define PEAK_RESET 16'h0000
`define RESLO_RESET 8'h00
`define WORD_RESET 16'h0000
// enhanced calibration duration in cycles
`define ENH_CAL_CYCLES 8'h40
`endif

/* verilog/disp_magnitude.v */
// display value converter: two's complement to sign and magnitude
// assumes a plain 16-bit value from logic on the same clock
`timescale 1ns/10ps
module disp_magnitude #(
   parameter WIDTH = 16
) (
   input wire [WIDTH-1:0] value,
   output reg negative,
   output reg [WIDTH-1:0] magnitude
);
   // negative values show magnitude less one, so -1 reads -0
   always @* begin
      negative = value[WIDTH-1];
      if (value[WIDTH-1]) begin
         magnitude = ~value;
      end else begin
         magnitude = value;
      end
   end
endmodule // disp_magnitude

/* dv/adc_peak_hold_monitor.sv */
// port checker for the result, peak and control block
// assumes binding onto every instance of adc_peak_hold
`timescale 1ns/10ps
module adc_peak_hold_monitor (
   input wire ref_clk,
   input wire rst,
   input wire [3:0] regIndex,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   input wire [15:0] regRdData,
   input wire regRdValid,
   input wire lowBatteryPin,
   input wire offsetCalPerConversion,
   input wire enhancedCalActive,
   input wire filterPowerdown,
   input wire displayPowerdown,
   input wire modulatorPowerdown,
   input wire inputBufferPowerdown,
   input wire peakAnnunciator,
   input wire holdAnnunciator,
   input wire segmentDirectSelect,
   input wire batteryLowAnnunciator
);
   // ==========================================
   // read port answers
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_RD_ANSWER: assert property (regRead |=> regRdValid)
      else $error("read not answered");
   AST_RD_PULSE: assert property (!regRead |=> !regRdValid)
      else $error("read valid without request");
   AST_LO_NIBBLE: assert property ((regRead && regIndex == 4'h4)
      |=> regRdData[3:0] == 4'h0) else $error("low nibble not zero");
   // ==========================================
   // control bits reach outputs two cycles on; enhanced calibration length and battery flag
   AST_PEAK_ANN: assert property ((regWrite && regIndex == 4'h0)
      |=> ##1 peakAnnunciator == $past(regWrData[0], 2))
      else $error("peak annunciator wrong");
   AST_HOLD_ANN: assert property ((regWrite && regIndex == 4'h0)
      |=> ##1 holdAnnunciator == $past(regWrData[1], 2))
      else $error("hold annunciator wrong");
   AST_SEGMENT_DIRECT_SELECT: assert property ((regWrite && regIndex == 4'h0)
      |=> ##1 segmentDirectSelect == $past(regWrData[7], 2))
      else $error("segment select wrong");
   AST_CAL_PER: assert property ((regWrite && regIndex == 4'h0)
      |=> ##1 offsetCalPerConversion == !$past(regWrData[3], 2))
      else $error("per conversion cal wrong");
   AST_DIG_PD: assert property ((regWrite && regIndex == 4'h0)
      |=> ##1 {filterPowerdown, displayPowerdown}
      == {2{$past(regWrData[5], 2)}}) else $error("digital pd wrong");
   AST_ANA_PD: assert property ((regWrite && regIndex == 4'h0)
      |=> ##1 {modulatorPowerdown, inputBufferPowerdown}
      == {2{$past(regWrData[6], 2)}}) else $error("analog pd wrong");
   AST_ENH_CAL: assert property ($rose(enhancedCalActive)
      |-> enhancedCalActive [*8]) else $error("enhanced cal too short");
   AST_BATT: assert property ((!displayPowerdown && lowBatteryPin) [*6]
      |-> batteryLowAnnunciator) else $error("battery flag missing");
endmodule // adc_peak_hold_monitor
bind adc_peak_hold adc_peak_hold_monitor mon (.ref_clk, .rst, .regIndex,
   .regWrData, .regWrite, .regRead, .regRdData, .regRdValid, .lowBatteryPin,
   .offsetCalPerConversion, .enhancedCalActive, .filterPowerdown,
   .displayPowerdown, .modulatorPowerdown, .inputBufferPowerdown,
   .peakAnnunciator, .holdAnnunciator, .segmentDirectSelect,
   .batteryLowAnnunciator);

/* dv/host_model.sv */
// host side model of the register port
// assumes requests are taken on the rising clock edge
`timescale 1ns/10ps
module host_model (
   input wire ref_clk,
   output reg [3:0] regIndex,
   output reg [15:0] regWrData,
   output reg regWrite,
   output reg regRead,
   input wire [15:0] regRdData,
   input wire regRdValid
);
   // idle port at time zero
   initial begin
      regIndex = 4'h0;
      regWrData = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // one write pulse, data scrambled after release
   task wr(input [3:0] idx, input [15:0] dat);
      begin
         @(posedge ref_clk);
         regIndex <= idx;
         regWrData <= dat;
         regWrite <= 1'b1;
         @(posedge ref_clk);
         regWrite <= 1'b0;
         regWrData <= ~dat;
      end
   endtask
   // one read pulse, answer taken the cycle after
   task rd(input [3:0] idx, output [15:0] dat, output ok);
      begin
         @(posedge ref_clk);
         regIndex <= idx;
         regRead <= 1'b1;
         @(posedge ref_clk);
         regRead <= 1'b0;
         #1;
         dat = regRdData;
         ok = regRdValid;
      end
   endtask
   // twenty bit result from both result registers
   function [19:0] join20(input [15:0] h, input [7:0] l);
      join20 = {h, l[7:4]};
   endfunction
endmodule // host_model

/* dv/adc_peak_hold_tb_top.sv */
// self-checking bench for the result, peak and control block
// assumes host model and checker are compiled beforehand
`timescale 1ns/10ps
module adc_peak_hold_tb_top;
   reg ref_clk, rst, sampleValid, lowBatteryPin, v;
   reg [19:0] calibratedSample, r;
   reg [15:0] d, hi, pk, off;
   integer seed, failures, num_checks, cycles, i;
   wire [3:0] regIndex;
   wire [15:0] regWrData, regRdData, dMag;
   wire regWrite, regRead, regRdValid, dNeg, fPd, mPd, calPer, enh, bLow;
   host_model host (.ref_clk(ref_clk), .regIndex(regIndex),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .regRdValid(regRdValid));
   adc_peak_hold DUT (.ref_clk(ref_clk), .rst(rst), .regIndex(regIndex),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .regRdValid(regRdValid),
      .calibratedSample(calibratedSample), .sampleValid(sampleValid),
      .lowBatteryPin(lowBatteryPin), .offsetCalPerConversion(calPer),
      .enhancedCalActive(enh), .filterPowerdown(fPd), .displayPowerdown(),
      .modulatorPowerdown(mPd), .inputBufferPowerdown(),
      .segmentDirectSelect(), .displayNegative(dNeg),
      .displayMagnitude(dMag), .peakAnnunciator(), .holdAnnunciator(),
      .batteryLowAnnunciator(bLow));
   // ==========================================
   // 25 MHz clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         stop_test;
      end
   end
   // ==========================================
   // helpers
   task chk(input [8*6-1:0] nm, input [19:0] e, input [19:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task rdc(input [3:0] idx, input [15:0] e);
      begin
         host.rd(idx, d, v);
         chk("reg", {1'b1, e}, {v, d});
      end
   endtask
   task smp(input [19:0] s);
      begin
         @(posedge ref_clk);
         calibratedSample <= s;
         sampleValid <= 1'b1;
         @(posedge ref_clk);
         sampleValid <= 1'b0;
         calibratedSample <= ~s;
         repeat (3) @(posedge ref_clk);
         #1;
      end
   endtask
   function [16:0] shown(input [15:0] x);
      shown = {x[15], x[15] ? ~x : x};
   endfunction
   task stop_test;
      begin
         $display("checks %0d failures %0d", num_checks, failures);
         if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      seed = 76;
      failures = 0;
      num_checks = 0;
      cycles = 0;
      rst = 1'b1;
      sampleValid = 1'b0;
      lowBatteryPin = 1'b0;
      calibratedSample = 20'h00000;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      for (i = 0; i < 9; i = i + 1)
         rdc(i[3:0], 16'h0000);
      off = $random(seed) % 64;
      host.wr(4'h2, off);
      for (i = 0; i < 12; i = i + 1) begin
         r = (i == 0) ? {off, 4'h0} - 20'h10 : $random(seed);
         smp(r);
         r = r - {off, 4'h0};
         host.rd(4'h3, hi, v);
         host.rd(4'h4, d, v);
         chk("result", r, host.join20(hi, d[7:0]));
         chk("disp", shown(r[19:4]), {dNeg, dMag});
      end
      $display("results test done");
      host.wr(4'h0, 16'h0001);
      pk = hi;
      rdc(4'h6, pk);
      for (i = 0; i < 12; i = i + 1) begin
         hi = (i == 0) ? pk : $random(seed) % 19000;
         smp({hi + off, 4'h0});
         if ($signed(hi) > $signed(pk)) pk = hi;
         rdc(4'h6, pk);
         chk("disp", shown(pk), {dNeg, dMag});
      end
      host.wr(4'h6, ~pk);
      rdc(4'h6, pk);
      host.wr(4'h0, 16'h0003);
      smp({16'h4e1f + off, 4'h0});
      chk("hold", shown(pk), {dNeg, dMag});
      host.wr(4'h0, 16'h0000);
      rdc(4'h6, 16'h0000);
      $display("peak test done");
      for (i = 0; i < 4; i = i + 1) begin
         host.wr(4'h0, {9'h0, i[1], i[0], 1'b0, i[0], 3'h0});
         r = $random(seed);
         smp(r);
         if (!i[0]) hi = r[19:4] - off;
         chk("pd", {i[0], i[1], ~i[0]}, {fPd, mPd, calPer});
         if (i[0]) rdc(4'h3, hi);
      end
      host.wr(4'h0, 16'h0000);
      lowBatteryPin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      host.rd(4'h1, d, v);
      chk("batt", 2'b11, {d[0], bLow});
      repeat (20) @(posedge ref_clk);
      host.wr(4'h0, 16'h0010);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("enh", 1'b1, enh);
      $display("control test done");
      stop_test;
   end
endmodule // adc_peak_hold_tb_top
